// ### pkg/adc_regs.svh
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

// ****************************************
// converter constants
// ****************************************
`define ADC_RES_BITS    12
`define ADC_CHAN_BITS   2
`define ADC_BUF_DEPTH   2
`define ADC_HOST_CLKS   16
`define ADC_DATA_RST    12'h000
`define ADC_CHAN_RST    2'h0

`endif

// ### pkg/adc_pkg.sv
package adc_pkg;

	// ****************************************
	// state types
	// ****************************************
	typedef enum logic [2:0] {
		CTL_IDLE,
		CTL_ARM,
		CTL_CONV,
		CTL_PDOWN
	} ctl_state_t;

	typedef enum logic [1:0] {
		ENG_IDLE,
		ENG_RUN,
		ENG_HOLD
	} eng_state_t;

endpackage : adc_pkg

// ### pkg/result_if.sv
`timescale 1ns/1ns
interface result_if #(
	parameter int W = 12
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : result_if

// ### hdl/result_buf.sv
`timescale 1ns/1ns
module result_buf #(
	parameter int W     = 12,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_reset_n,
	// filling side
	result_if.snk             in_bus,
	// draining side
	output logic              o_out_valid,
	output logic [W-1:0]      o_out_data,
	input  wire logic         i_out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("result_buf depth must be a power of two, at least 2");
	end

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0]   count_q;
	wire           push;
	wire           pop;

	assign in_bus.ready = (count_q != (AW+1)'(DEPTH));
	assign o_out_valid  = (count_q != '0);
	assign o_out_data   = mem_q[rd_ptr_q];
	assign push         = in_bus.valid & in_bus.ready;
	assign pop          = o_out_valid & i_out_ready;

	// ****************************************
	// storage, one flop row per entry
	// ****************************************
	for (genvar e = 0; e < DEPTH; e++) begin : g_entry
		always_ff @(posedge i_clk or negedge i_reset_n) begin
			if (!i_reset_n)
				mem_q[e] <= '0;
			else if (push && wr_ptr_q == AW'(e))
				mem_q[e] <= in_bus.data;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push)
				wr_ptr_q <= wr_ptr_q + AW'(1);
			if (pop)
				rd_ptr_q <= rd_ptr_q + AW'(1);
			if (push && !pop)
				count_q <= count_q + (AW+1)'(1);
			else if (pop && !push)
				count_q <= count_q - (AW+1)'(1);
		end
	end
endmodule : result_buf

// ### hdl/sar_engine.sv
`timescale 1ns/1ns
module sar_engine #(
	parameter int WIDTH = 12
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_reset_n,
	// control
	input  wire logic         i_start,
	input  wire logic         i_step,
	input  wire logic         i_comp,
	output logic [WIDTH-1:0]  o_trial,
	output logic              o_active,
	// finished word
	result_if.src             res
);
	if (WIDTH < 2) begin : g_bad_width
		$error("sar_engine width must be at least 2");
	end

	adc_pkg::eng_state_t state_q;
	logic [WIDTH-1:0]    code_q;
	logic [WIDTH-1:0]    mask_q;
	wire  [WIDTH-1:0]    trial;
	wire  [WIDTH-1:0]    kept;
	wire  [WIDTH-1:0]    msb_mask;

	assign msb_mask  = {1'b1, {(WIDTH-1){1'b0}}};
	assign trial     = code_q | mask_q;
	// comparator high: input at or above trial, bit stays set
	assign kept      = i_comp ? trial : code_q;  // [RL8]
	assign o_trial   = trial;
	assign o_active  = (state_q != adc_pkg::ENG_IDLE);
	assign res.valid = (state_q == adc_pkg::ENG_HOLD);
	assign res.data  = code_q;

	// ****************************************
	// one decision per conversion clock, msb first
	// ****************************************
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= adc_pkg::ENG_IDLE;
			code_q  <= '0;
			mask_q  <= '0;
		end else begin
			unique case (state_q)
				adc_pkg::ENG_IDLE: begin
					if (i_start) begin
						state_q <= adc_pkg::ENG_RUN;
						code_q  <= '0;
						mask_q  <= msb_mask;  // [RL3]
					end
				end
				adc_pkg::ENG_RUN: begin
					if (i_step) begin
						code_q <= kept;  // [RL3]
						mask_q <= mask_q >> 1;
						if (mask_q[0])
							state_q <= adc_pkg::ENG_HOLD;
					end
				end
				adc_pkg::ENG_HOLD: begin
					if (res.ready)
						state_q <= adc_pkg::ENG_IDLE;
				end
			endcase
		end
	end
endmodule : sar_engine

// ### hdl/sar_adc_ctrl.sv
`timescale 1ns/1ns
`include "adc_regs.svh"

// What this block does
// RL1 - falling write strobe with select low and valid address starts a conversion
// RL2 - converting state begins at first conversion clock rise after write falls
// RL3 - one bit decided per conversion clock after the first, msb first, lsb on thirteenth
// RL4 - busy output held low throughout a conversion
// RL5 - busy rises when conversion ends; the 12-bit result is then readable; with the result buffer full, busy stays low until a read frees an entry
// RL6 - host gives sixteen conversion clocks per conversion
// RL7 - result bus driven only while select and read strobe both low
// RL8 - results coded straight binary, zero to full scale 0xFFF
// RL9 - valid result shown once select and read strobe are low
// RL10 - host reads only after busy has returned high
// RL11 - read rise with select low, low address high, busy high enters power-down
// RL12 - read rise with select low and low address low wakes the device
// RL13 - power-down turns all converter circuitry off
// RL14 - host should read each result straight after its conversion
// RL15 - host may capture the result on busy rising
// RL16 - two address lines pick one of four input channels
// RL17 - channel and sample latched at write fall; later address changes ignored
module sar_adc_ctrl #(
	parameter int WIDTH = `ADC_RES_BITS,
	parameter int DEPTH = `ADC_BUF_DEPTH
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	// host parallel bus
	input  wire logic             i_conv_clk,
	input  wire logic             i_cs_n,
	input  wire logic             i_wr_n,
	input  wire logic             i_rd_n,
	input  wire logic             i_low_addr_line,
	input  wire logic             i_high_addr_line,
	output logic                  o_busy_n,
	output logic [WIDTH-1:0]      o_data_out,
	output logic                  o_data_oe,
	// analog front end
	input  wire logic             i_comp,
	output logic [`ADC_CHAN_BITS-1:0] o_chan_sel,
	output logic                  o_hold,
	output logic [WIDTH-1:0]      o_capacitive_dac,
	output logic                  o_power_down
);
	if (WIDTH != `ADC_RES_BITS) begin : g_bad_width
		$error("sar_adc_ctrl supports only the 12-bit result width");
	end

	// ****************************************
	// pin history and edge decode
	// ****************************************
	logic conv_clk_q;
	logic wr_n_q;
	logic rd_n_q;
	logic sel_rd_q;

	wire  step;
	wire  wr_fall;
	wire  rd_rise;
	wire  sel_rd;
	wire  read_end;

	assign step     = i_conv_clk & ~conv_clk_q;
	assign wr_fall  = wr_n_q & ~i_wr_n;
	assign rd_rise  = ~rd_n_q & i_rd_n;
	assign sel_rd   = ~i_cs_n & ~i_rd_n;
	assign read_end = sel_rd_q & ~sel_rd;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			conv_clk_q <= 1'b0;
			wr_n_q     <= 1'b1;
			rd_n_q     <= 1'b1;
			sel_rd_q   <= 1'b0;
		end else begin
			conv_clk_q <= i_conv_clk;
			wr_n_q     <= i_wr_n;
			rd_n_q     <= i_rd_n;
			sel_rd_q   <= sel_rd;
		end
	end

	// ****************************************
	// control state machine
	// ****************************************
	adc_pkg::ctl_state_t state_q;
	adc_pkg::ctl_state_t state_d;

	logic busy_n_q;
	wire  start_req;
	wire  pd_enter;
	wire  pd_wake;
	wire  eng_start;
	wire  word_pushed;
	wire  in_pdown;

	result_if #(.W(WIDTH)) res_bus ();

	assign in_pdown    = (state_q == adc_pkg::CTL_PDOWN);
	assign start_req   = wr_fall & ~i_cs_n;  // [RL1]
	assign pd_enter    = rd_rise & ~i_cs_n & i_low_addr_line & busy_n_q;  // [RL11]
	assign pd_wake     = rd_rise & ~i_cs_n & ~i_low_addr_line;  // [RL12]
	assign eng_start   = (state_q == adc_pkg::CTL_ARM) & step;  // [RL2]
	assign word_pushed = res_bus.valid & res_bus.ready;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			adc_pkg::CTL_IDLE: begin
				if (start_req)
					state_d = adc_pkg::CTL_ARM;
				else if (pd_enter)
					state_d = adc_pkg::CTL_PDOWN;
			end
			adc_pkg::CTL_ARM: begin
				if (step)
					state_d = adc_pkg::CTL_CONV;  // [RL2]
			end
			adc_pkg::CTL_CONV: begin
				if (word_pushed)
					state_d = adc_pkg::CTL_IDLE;  // [RL5]
			end
			adc_pkg::CTL_PDOWN: begin
				if (pd_wake)
					state_d = adc_pkg::CTL_IDLE;  // [RL12]
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			state_q <= adc_pkg::CTL_IDLE;
		else
			state_q <= state_d;
	end

	// ****************************************
	// busy, hold and channel latch
	// ****************************************
	logic [`ADC_CHAN_BITS-1:0] chan_q;
	logic                      hold_q;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			busy_n_q <= 1'b1;
			hold_q   <= 1'b0;
			chan_q   <= `ADC_CHAN_RST;
		end else begin
			if (state_q == adc_pkg::CTL_IDLE && start_req) begin
				busy_n_q <= 1'b0;  // [RL4]
				hold_q   <= 1'b1;  // [RL17]
				chan_q   <= {i_high_addr_line, i_low_addr_line};  // [RL16] [RL17]
			end else if (state_q == adc_pkg::CTL_CONV && word_pushed) begin
				busy_n_q <= 1'b1;  // [RL5]
				hold_q   <= 1'b0;
			end
		end
	end

	// ****************************************
	// approximation engine and result buffer
	// ****************************************
	logic [WIDTH-1:0] trial;
	logic             eng_active;
	logic             buf_valid;
	logic [WIDTH-1:0] buf_head;
	wire              buf_pop;

	// a word leaves the buffer when its read cycle ends
	assign buf_pop = read_end & buf_valid;

	sar_engine #(
		.WIDTH (WIDTH)
	) u_engine (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_start   (eng_start),
		.i_step    (step),
		.i_comp    (i_comp),
		.o_trial   (trial),
		.o_active  (eng_active),
		.res       (res_bus.src)
	);

	result_buf #(
		.W     (WIDTH),
		.DEPTH (DEPTH)
	) u_buf (
		.i_clk       (i_clk),
		.i_reset_n   (i_reset_n),
		.in_bus      (res_bus.snk),
		.o_out_valid (buf_valid),
		.o_out_data  (buf_head),
		.i_out_ready (buf_pop)
	);

	// ****************************************
	// front end and read-out registers
	// ****************************************
	logic [WIDTH-1:0] dac_q;
	logic [WIDTH-1:0] data_q;
	logic             oe_q;
	logic             pdown_q;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dac_q   <= `ADC_DATA_RST;
			data_q  <= `ADC_DATA_RST;
			oe_q    <= 1'b0;
			pdown_q <= 1'b0;
		end else begin
			pdown_q <= (state_d == adc_pkg::CTL_PDOWN);  // [RL13]
			dac_q   <= (eng_active && !in_pdown) ? trial : `ADC_DATA_RST;  // [RL13]
			oe_q    <= sel_rd & ~in_pdown;  // [RL7]
			if (buf_valid && !in_pdown)
				data_q <= buf_head;  // [RL9]
		end
	end

	assign o_busy_n         = busy_n_q;
	assign o_data_out       = data_q;
	assign o_data_oe        = oe_q;
	assign o_chan_sel       = chan_q;
	assign o_hold           = hold_q;
	assign o_capacitive_dac = dac_q;
	assign o_power_down     = pdown_q;
endmodule : sar_adc_ctrl

// ### bench/adc_frontend_model.sv
`timescale 1ns/1ns
module adc_frontend_model (
	// dut side
	input  wire logic [11:0] i_trial,
	input  wire logic [1:0]  i_chan,
	input  wire logic [47:0] i_levels,
	output logic             o_comp
);
	// ****
	// comparator
	// ****
	assign o_comp = i_levels[i_chan*12 +: 12] >= i_trial;
endmodule : adc_frontend_model

// ### bench/sar_adc_ctrl_properties.sv
`timescale 1ns/1ns
`include "adc_regs.svh"
module sar_adc_ctrl_properties #(
	parameter int WIDTH = 12
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// host bus
	input wire logic i_conv_clk,
	input wire logic i_cs_n,
	input wire logic i_wr_n,
	input wire logic i_rd_n,
	input wire logic i_low_addr_line,
	input wire logic i_high_addr_line,
	input wire logic o_busy_n,
	input wire logic [WIDTH-1:0] o_data_out,
	input wire logic o_data_oe,
	// front end
	input wire logic i_comp,
	input wire logic [`ADC_CHAN_BITS-1:0] o_chan_sel,
	input wire logic o_hold,
	input wire logic [WIDTH-1:0] o_capacitive_dac,
	input wire logic o_power_down
);
	// ****
	// edge history
	// ****
	logic wr_q;
	logic rd_q;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_q <= 1'b1;
			rd_q <= 1'b1;
		end else begin
			wr_q <= i_wr_n;
			rd_q <= i_rd_n;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_start;
		!i_wr_n && wr_q && !i_cs_n && o_busy_n && !o_power_down;
	endsequence
	sequence s_rd_rise;
		i_rd_n && !rd_q && !i_cs_n;
	endsequence
	// ****
	// properties
	// ****
	a_start_busy: assert property (s_start |-> ##[1:2] !o_busy_n)
		else $error("busy not low after start");
	a_busy_hold: assert property ($fell(o_busy_n) |-> o_hold)
		else $error("busy low without hold");
	a_end_release: assert property ($rose(o_busy_n) |-> !o_hold)
		else $error("busy high while holding");
	a_chan_stable: assert property (!o_busy_n && !$past(o_busy_n) |-> $stable(o_chan_sel))
		else $error("channel changed in conversion");
	a_msb_first: assert property ($past(o_capacitive_dac) == 12'h000
		&& o_capacitive_dac != 12'h000 |-> o_capacitive_dac == 12'h800)
		else $error("first trial not midscale");
	a_oe_cause: assert property (o_data_oe |-> $past(i_cs_n) == 1'b0 && $past(i_rd_n) == 1'b0)
		else $error("bus driven without read");
	a_oe_answer: assert property (!i_cs_n && !i_rd_n && !o_power_down |-> ##[1:2] o_data_oe)
		else $error("bus not driven on read");
	a_pd_enter: assert property (s_rd_rise ##0 (i_low_addr_line && o_busy_n && !o_power_down)
		|-> ##[1:2] o_power_down)
		else $error("power-down not entered");
	a_pd_wake: assert property (s_rd_rise ##0 (!i_low_addr_line && o_power_down)
		|-> ##[1:2] !o_power_down)
		else $error("wake-up not taken");
	a_pd_quiet: assert property (o_power_down |-> !o_data_oe && o_capacitive_dac == 12'h000)
		else $error("activity in power-down");
endmodule : sar_adc_ctrl_properties

// ### bench/tb_quad_channel_sar_adc_parallel_if.sv
`timescale 1ns/1ns
`include "adc_regs.svh"
module tb_quad_channel_sar_adc_parallel_if;
	// ****
	// signals
	// ****
	logic        i_clk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic        conv_clk = 1'b0;
	logic        cs_n = 1'b1;
	logic        wr_n = 1'b1;
	logic        rd_n = 1'b1;
	logic [1:0]  addr = 2'h0;
	logic [47:0] levels = 48'h0;
	logic        comp;
	logic        busy_n;
	logic        oe;
	logic        pd;
	logic        hold;
	logic [11:0] data;
	logic [11:0] trial;
	logic [1:0]  chan;
	logic [11:0] exp_q[$];
	logic        oe_q = 1'b0;
	logic [15:0] lfsr = 16'h004D;
	int          failures = 0;
	int          comparisons = 0;
	sar_adc_ctrl u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_conv_clk(conv_clk),
		.i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n), .i_low_addr_line(addr[0]),
		.i_high_addr_line(addr[1]), .o_busy_n(busy_n), .o_data_out(data), .o_data_oe(oe),
		.i_comp(comp), .o_chan_sel(chan), .o_hold(hold), .o_capacitive_dac(trial),
		.o_power_down(pd));
	adc_frontend_model u_model (.i_trial(trial), .i_chan(chan), .i_levels(levels), .o_comp(comp));
	// ****
	// tasks
	// ****
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic end_sim;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	task automatic convert(input logic [1:0] ch, input logic [11:0] v);
		int i;
		@(posedge i_clk);
		levels[ch*12 +: 12] <= v;
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		addr <= ch;
		exp_q.push_back(v);
		cyc(1);
		wr_n <= 1'b1;
		cs_n <= 1'b1;
		addr <= ~ch;
		cyc(3);
		chk("chan", {10'h0, ch}, {10'h0, chan});
		chk("busy", 12'h0, {11'h0, busy_n});
		chk("hold", 12'h1, {11'h0, hold});
		repeat (`ADC_HOST_CLKS) begin
			conv_clk <= 1'b1;
			cyc(3);
			conv_clk <= 1'b0;
			cyc(3);
		end
		for (i = 0; i < 40 && busy_n !== 1'b1; i++) cyc(1);
	endtask : convert
	task automatic read_word(input logic low_addr);
		@(posedge i_clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		addr <= {1'b0, low_addr};
		cyc(3);
		rd_n <= 1'b1;
		cyc(2);
		cs_n <= 1'b1;
		cyc(3);
	endtask : read_word
	// ****
	// clock, scoreboard, watchdog
	// ****
	initial forever #2 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		oe_q <= oe;
		if (oe === 1'b1 && oe_q === 1'b0) begin
			chk("data", exp_q.size() > 0 ? exp_q.pop_front() : 12'hXXX, data);
		end
	end
	initial begin
		#200000;
		failures++;
		$display("watchdog expired");
		end_sim();
	end
	// ****
	// tests
	// ****
	initial begin
		logic [11:0] codes[4];
		int k;
		codes = '{12'h000, 12'h7FF, 12'h800, 12'hFFF};
		repeat (8) @(posedge i_clk);
		i_reset_n <= 1'b1;
		cyc(2);
		for (k = 0; k < 8; k++) begin
			lfsr = lfsr_next(lfsr);
			convert(k[1:0], k < 4 ? codes[k] : lfsr[11:0]);
			chk("busy end", 12'h1, {11'h0, busy_n});
			chk("hold end", 12'h0, {11'h0, hold});
			read_word(1'b0);
			chk("released", 12'h0, {11'h0, oe});
		end
		@(posedge i_clk);
		wr_n <= 1'b0;
		cyc(3);
		chk("no select", 12'h1, {11'h0, busy_n});
		wr_n <= 1'b1;
		$display("test codes done");
		for (k = 0; k < 3; k++) begin
			lfsr = lfsr_next(lfsr);
			convert(k[1:0], lfsr[11:0]);
		end
		chk("full hold", 12'h0, {11'h0, busy_n});
		read_word(1'b0);
		cyc(4);
		chk("freed", 12'h1, {11'h0, busy_n});
		read_word(1'b0);
		read_word(1'b0);
		$display("test buffer done");
		convert(2'h2, 12'h5A5);
		read_word(1'b1);
		chk("pd on", 12'h1, {11'h0, pd});
		@(posedge i_clk);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		cyc(3);
		chk("pd start", 12'h1, {11'h0, busy_n});
		wr_n <= 1'b1;
		rd_n <= 1'b0;
		addr <= 2'h0;
		cyc(3);
		chk("pd bus", 12'h0, {11'h0, oe});
		rd_n <= 1'b1;
		cyc(3);
		cs_n <= 1'b1;
		chk("pd off", 12'h0, {11'h0, pd});
		convert(2'h1, 12'h123);
		read_word(1'b0);
		cyc(2);
		chk("queue left", 12'h0, 12'(exp_q.size()));
		$display("test power done");
		end_sim();
	end
endmodule : tb_quad_channel_sar_adc_parallel_if

bind sar_adc_ctrl sar_adc_ctrl_properties #(.WIDTH(WIDTH)) u_props (.i_clk(i_clk),
	.i_reset_n(i_reset_n), .i_conv_clk(i_conv_clk), .i_cs_n(i_cs_n), .i_wr_n(i_wr_n),
	.i_rd_n(i_rd_n), .i_low_addr_line(i_low_addr_line), .i_high_addr_line(i_high_addr_line),
	.o_busy_n(o_busy_n), .o_data_out(o_data_out), .o_data_oe(o_data_oe), .i_comp(i_comp),
	.o_chan_sel(o_chan_sel), .o_hold(o_hold), .o_capacitive_dac(o_capacitive_dac),
	.o_power_down(o_power_down));
